//--- rtl/cpu_core_consts.svh
// Bit positions, reset values, offsets and step sizes for the CPU core register set
`ifndef CPU_CORE_CONSTS_SVH
`define CPU_CORE_CONSTS_SVH

`define FLAG_ZERO_BIT    1
`define FLAG_CARRY_BIT   2
`define FLAG_SUPER_BIT   3
`define FLAG_BANK_BIT    4
`define FLAG_IEN_BIT     0
`define FLAG_RESET       8'h02
`define FLAG_USER_MASK   8'h17
`define FLAG_READ_ADDR   8'hF7
`define BYTE_ZERO        8'h00
`define PC_RESET         16'h0000
`define PC_MIN_WIDTH     13
`define PC_MAX_WIDTH     16
`define INSTR_LEN        16'h0002
`define SP_STEP_PUSH     8'h01
`define SP_STEP_CALL     8'h02
`define SP_STEP_RETURN_FROM_INTERRUPT_OP     8'h03

`endif

//--- rtl/cpu_core_pkg.sv
// Types shared by the CPU core register set and its sequencer
package cpu_core_pkg;

	// Operation applied to the selected destination
	typedef enum logic [3:0] {
		OP_MOV  = 4'h0,
		OP_ADD  = 4'h1,
		OP_ADC  = 4'h2,
		OP_SUB  = 4'h3,
		OP_SBB  = 4'h4,
		OP_AND  = 4'h5,
		OP_OR   = 4'h6,
		OP_XOR  = 4'h7,
		OP_SHL  = 4'h8,
		OP_SHR  = 4'h9,
		OP_SWAP = 4'hA
	} alu_op_t;

	// Where the second source byte comes from
	typedef enum logic [1:0] {
		MODE_IMMEDIATE = 2'h0,
		MODE_DIRECT    = 2'h1,
		MODE_INDEXED   = 2'h2
	} addr_mode_t;

	// Core register that takes the result
	typedef enum logic [1:0] {
		DST_ACC   = 2'h0,
		DST_INDEX = 2'h1,
		DST_SP    = 2'h2,
		DST_FLAGS = 2'h3
	} dest_t;

	// Stack pointer movement requested by the sequencer
	typedef enum logic [2:0] {
		STK_NONE = 3'h0,
		STK_PUSH = 3'h1,
		STK_POP  = 3'h2,
		STK_CALL = 3'h3,
		STK_RET  = 3'h4,
		STK_RETURN_FROM_INTERRUPT_OP = 3'h5
	} stack_cmd_t;

	// One-hot execution states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_FETCH = 3'b010,
		ST_EXEC  = 3'b100
	} exec_state_t;

endpackage

//--- rtl/cpu_core_register_set.sv
// Core register set of an 8-bit Harvard CPU with source addressing modes
`include "cpu_core_consts.svh"

module cpu_core_register_set #(
	parameter int PC_W = 16                          // Program counter width
) (
	input  wire logic                    clk,           // 25 MHz core clock
	input  wire logic                    reset,         // Synchronous, active high
	input  wire logic                    clk_en,        // Freezes all state when low
	input  wire logic                    op_valid,      // Operation offered
	input  wire cpu_core_pkg::alu_op_t   op_kind,       // Operation to perform
	input  wire cpu_core_pkg::addr_mode_t op_mode,      // Source addressing mode
	input  wire cpu_core_pkg::dest_t     op_dest,       // Destination register
	input  wire logic [7:0]              op_operand,    // Second instruction byte
	output logic                         op_ready,      // Operation may be offered
	output logic                         op_done,       // Operation retired
	output logic                         op_refused,    // Illegal destination ignored
	output logic                         mem_req,       // Source read request
	output logic [7:0]                   mem_addr,      // Source address
	input  wire logic                    mem_ack,       // Source data valid
	input  wire logic [7:0]              mem_rdata,     // Source data
	input  wire cpu_core_pkg::stack_cmd_t stack_cmd,    // Stack pointer movement
	input  wire logic                    pc_load_en,    // Load a jump target
	input  wire logic [PC_W-1:0]         pc_load_val,   // Jump target
	input  wire logic                    super_enter,   // Enter supervisor code
	input  wire logic                    super_leave,   // Return to user code
	input  wire logic                    irq_pending,   // Interrupt request from system
	output logic                         irq_take,      // Interrupt accepted
	input  wire logic                    reg_rd_en,     // Register space read
	input  wire logic [7:0]              reg_rd_addr,   // Register space address
	output logic [7:0]                   reg_rd_data,   // Register space read data
	output logic [7:0]                   accumulator,   // Accumulator value
	output logic [7:0]                   index_offset,  // Index register value
	output logic [7:0]                   stack_top_pointer, // Stack pointer value
	output logic [7:0]                   program_counter_high, // PC high byte
	output logic [7:0]                   program_counter_low,  // PC low byte
	output logic [7:0]                   status_flags,  // Flags register value
	output logic                         register_bank_select, // Register bank
	output logic                         interrupt_master_enable // Global enable
);
	import cpu_core_pkg::*;

	// Parameter check at elaboration: the PC must reach all program memory
	// and still split into two bytes
	if (PC_W < `PC_MIN_WIDTH || PC_W > `PC_MAX_WIDTH) begin : g_pc_w_bad
		$error("PC_W must cover the program memory and fit two bytes");
	end

	// Architectural registers
	// The PC is always held at 16 bits so both byte views exist;
	// a narrow PC_W only leaves the upper bits at zero
	logic [7:0]      acc_q, acc_d;       // Accumulator
	logic [7:0]      idx_q, idx_d;       // Index register
	logic [7:0]      sp_q, sp_d;         // Stack pointer
	logic [15:0]     pc_q, pc_d;         // Program counter, upper bits zero if narrow
	logic [7:0]      flags_q, flags_d;   // Flags register

	// Sequencing state
	// Operation fields are latched at the take edge, so the caller may move on
	exec_state_t     state_q, state_d;   // Execution state
	alu_op_t         op_q, op_d;         // Latched operation
	dest_t           dst_q, dst_d;       // Latched destination
	addr_mode_t      mode_q, mode_d;     // Latched mode
	logic [7:0]      src_q, src_d;       // Second source byte
	logic [7:0]      maddr_q, maddr_d;   // Source address
	logic            mreq_q, mreq_d;     // Source read pending
	logic            done_q, done_d;     // Retire pulse
	logic            refuse_q, refuse_d; // Refusal pulse
	logic            irq_q, irq_d;       // Interrupt accept pulse
	logic [7:0]      rdat_q, rdat_d;     // Register space read data

	// Ready flag kept in a flop so op_ready needs no decode
	logic            ready_q, ready_d;   // Idle, operation may be offered

	// ALU scratch
	// Shared by all destinations; the chosen one is written, A as well on a swap into SP, and zero and carry for A or X results except MOV and SWAP
	logic [7:0]      first_src;          // First source from destination
	logic [8:0]      alu_full;           // Result with carry
	logic            alu_carry;          // Carry out
	logic            flags_touch;        // Operation writes zero and carry
	logic [15:0]     pc_mask;            // Keeps PC within PC_W bits

	// First source for arithmetic is the register named by the destination
	// SP and flags only reach the ALU through immediate operations
	always_comb begin
		unique case (dst_q)
			DST_ACC:   first_src = acc_q;
			DST_INDEX: first_src = idx_q;
			DST_SP:    first_src = sp_q;
			DST_FLAGS: first_src = flags_q;
		endcase
	end

	// Result and carry per operation; bit 8 of the sum is the carry or borrow
	// Carry into ADC and SBB is the stored carry flag, shifts ignore the operand
	always_comb begin
		alu_full    = {1'b0, src_q};
		flags_touch = 1'b1;
		unique case (op_q)
			OP_MOV: begin
				alu_full    = {1'b0, src_q};
				flags_touch = 1'b0;
			end
			OP_ADD:  alu_full = {1'b0, first_src} + {1'b0, src_q};
			OP_ADC:  alu_full = {1'b0, first_src} + {1'b0, src_q}
				+ {8'h00, flags_q[`FLAG_CARRY_BIT]};
			OP_SUB:  alu_full = {1'b0, first_src} - {1'b0, src_q};
			OP_SBB:  alu_full = {1'b0, first_src} - {1'b0, src_q}
				- {8'h00, flags_q[`FLAG_CARRY_BIT]};
			// Logic operations never carry
			OP_AND:  alu_full = {1'b0, first_src & src_q};
			OP_OR:   alu_full = {1'b0, first_src | src_q};
			OP_XOR:  alu_full = {1'b0, first_src ^ src_q};
			// Shifts push the bit shifted out into carry
			OP_SHL:  alu_full = {first_src, 1'b0};
			OP_SHR:  alu_full = {first_src[0], 1'b0, first_src[7:1]};
			OP_SWAP: begin
				alu_full    = {1'b0, acc_q};
				flags_touch = 1'b0;
			end
			default: begin
				alu_full    = {1'b0, src_q};
				flags_touch = 1'b0;
			end
		endcase
		alu_carry = alu_full[8];
	end

	// Wraps the PC at its own width when PC_W is narrow
	assign pc_mask = 16'hFFFF >> (16 - PC_W);

	// Next values for sequencing and the core registers
	always_comb begin
		acc_d    = acc_q;
		idx_d    = idx_q;
		sp_d     = sp_q;
		pc_d     = pc_q;
		flags_d  = flags_q;
		state_d  = state_q;
		op_d     = op_q;
		dst_d    = dst_q;
		mode_d   = mode_q;
		src_d    = src_q;
		maddr_d  = maddr_q;
		mreq_d   = mreq_q;
		done_d   = 1'b0;
		refuse_d = 1'b0;
		// A pending interrupt is only accepted while the global enable is set
		irq_d    = irq_pending & flags_q[`FLAG_IEN_BIT];

		// Only the flags answer in register space
		rdat_d   = `BYTE_ZERO;
		if (reg_rd_en && reg_rd_addr == `FLAG_READ_ADDR) begin
			rdat_d = flags_q;
		end

		// Stack movement from the sequencer; a result written to SP below wins
		// Moves count bytes of data memory
		unique case (stack_cmd)
			STK_PUSH: sp_d = sp_q + `SP_STEP_PUSH;
			STK_POP:  sp_d = sp_q - `SP_STEP_PUSH;
			STK_CALL: sp_d = sp_q + `SP_STEP_CALL;
			STK_RET:  sp_d = sp_q - `SP_STEP_CALL;
			STK_RETURN_FROM_INTERRUPT_OP: sp_d = sp_q - `SP_STEP_RETURN_FROM_INTERRUPT_OP;
			default:  sp_d = sp_q;
		endcase

		// Supervisory state changes only by hardware
		if (super_enter) begin
			flags_d[`FLAG_SUPER_BIT] = 1'b1;
		end else if (super_leave) begin
			flags_d[`FLAG_SUPER_BIT] = 1'b0;
		end

		// Operation sequencing
		unique case (state_q)
			ST_IDLE: begin
				// Accept an operation and form the source address
				// Indexed address wraps within 256 bytes
				if (op_valid) begin
					op_d   = op_kind;
					dst_d  = op_dest;
					mode_d = op_mode;
					src_d  = op_operand;
					unique case (op_mode)
						MODE_DIRECT: begin
							maddr_d = op_operand;
							mreq_d  = 1'b1;
							state_d = ST_FETCH;
						end
						MODE_INDEXED: begin
							maddr_d = op_operand + idx_q;
							mreq_d  = 1'b1;
							state_d = ST_FETCH;
						end
						// Immediate operand needs no fetch
						default: state_d = ST_EXEC;
					endcase
				end
			end
			ST_FETCH: begin
				// Wait for the addressed source byte
				// Address and request stand until the acknowledge
				if (mem_ack) begin
					src_d   = mem_rdata;
					mreq_d  = 1'b0;
					state_d = ST_EXEC;
				end
			end
			ST_EXEC: begin
				// Commit the result to the chosen register
				// Every retired operation is two bytes long
				state_d = ST_IDLE;
				done_d  = 1'b1;
				if (!pc_load_en) begin
					pc_d = (pc_q + `INSTR_LEN) & pc_mask;
				end
				// Direct and indexed sources only reach A or X
				if (mode_q != MODE_IMMEDIATE && (dst_q == DST_SP || dst_q == DST_FLAGS)) begin
					refuse_d = 1'b1;
				end else begin
					unique case (dst_q)
						DST_ACC: begin
							acc_d = alu_full[7:0];
						end
						DST_INDEX: begin
							idx_d = alu_full[7:0];
						end
						DST_SP: begin
							sp_d = alu_full[7:0];
							// Swap trades A and SP in one cycle
							if (op_q == OP_SWAP) begin
								acc_d = sp_q;
							end
						end
						DST_FLAGS: begin
							// Flags only through AND or OR, super kept
							// Reserved bits stay zero, super follows the hardware inputs
							if (op_q == OP_AND) begin
								flags_d = ((flags_q & src_q) & `FLAG_USER_MASK)
									| (flags_d & ~`FLAG_USER_MASK);
							end else if (op_q == OP_OR) begin
								flags_d = ((flags_q | src_q) & `FLAG_USER_MASK)
									| (flags_d & ~`FLAG_USER_MASK);
							end else begin
								refuse_d = 1'b1;
							end
						end
					endcase
					// Results to A or X set zero and carry except for MOV and SWAP; SP and flags keep them
					if (flags_touch && dst_q != DST_FLAGS && dst_q != DST_SP) begin
						flags_d[`FLAG_CARRY_BIT] = alu_carry;
						flags_d[`FLAG_ZERO_BIT]  = (alu_full[7:0] == `BYTE_ZERO);
					end
				end
			end
			default: state_d = ST_IDLE;
		endcase
		// A jump target loaded this cycle wins over the step
		if (pc_load_en) begin
			pc_d = 16'(pc_load_val);
		end
		// Ready follows the state about to be entered
		ready_d  = (state_d == ST_IDLE);
	end

	// Register all state; reset gives zeroes, the zero flag, the idle state and ready set
	// Reset wins over a low clock enable so the core always starts clean
	always_ff @(posedge clk) begin
		if (reset) begin
			acc_q    <= `BYTE_ZERO;
			idx_q    <= `BYTE_ZERO;
			sp_q     <= `BYTE_ZERO;
			pc_q     <= `PC_RESET;
			flags_q  <= `FLAG_RESET;
			state_q  <= ST_IDLE;
			op_q     <= OP_MOV;
			dst_q    <= DST_ACC;
			mode_q   <= MODE_IMMEDIATE;
			src_q    <= `BYTE_ZERO;
			maddr_q  <= `BYTE_ZERO;
			mreq_q   <= 1'b0;
			done_q   <= 1'b0;
			refuse_q <= 1'b0;
			irq_q    <= 1'b0;
			rdat_q   <= `BYTE_ZERO;
			ready_q  <= 1'b1;
		end else if (clk_en) begin
			acc_q    <= acc_d;
			idx_q    <= idx_d;
			sp_q     <= sp_d;
			pc_q     <= pc_d;
			flags_q  <= flags_d;
			state_q  <= state_d;
			op_q     <= op_d;
			dst_q    <= dst_d;
			mode_q   <= mode_d;
			src_q    <= src_d;
			maddr_q  <= maddr_d;
			mreq_q   <= mreq_d;
			done_q   <= done_d;
			refuse_q <= refuse_d;
			irq_q    <= irq_d;
			rdat_q   <= rdat_d;
			ready_q  <= ready_d;
		end
	end

	// Outputs straight from flip-flops
	// Bank select and interrupt enable are bits of the flags flop
	assign op_ready                = ready_q;
	assign op_done                 = done_q;
	assign op_refused              = refuse_q;
	assign mem_req                 = mreq_q;
	assign mem_addr                = maddr_q;
	assign irq_take                = irq_q;
	assign reg_rd_data             = rdat_q;
	assign accumulator             = acc_q;
	assign index_offset            = idx_q;
	assign stack_top_pointer       = sp_q;
	assign program_counter_high    = pc_q[15:8];
	assign program_counter_low     = pc_q[7:0];
	assign status_flags            = flags_q;
	assign register_bank_select    = flags_q[`FLAG_BANK_BIT];
	assign interrupt_master_enable = flags_q[`FLAG_IEN_BIT];

endmodule

//--- tb/cpu_core_register_set_sva.sv
// Port-level checker for the CPU core register set
module cpu_core_register_set_sva
	import cpu_core_pkg::*;
#(
	parameter int PC_W = 16 // Program counter width
) (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       clk_en,
	input wire logic       op_valid,
	input wire addr_mode_t op_mode,
	input wire logic       op_ready,
	input wire logic       op_done,
	input wire logic       op_refused,
	input wire logic       mem_req,
	input wire logic [7:0] mem_addr,
	input wire logic       mem_ack,
	input wire logic       pc_load_en,
	input wire logic       super_enter,
	input wire logic       irq_take,
	input wire logic       reg_rd_en,
	input wire logic [7:0] reg_rd_addr,
	input wire logic [7:0] reg_rd_data,
	input wire logic [7:0] accumulator,
	input wire logic [7:0] stack_top_pointer,
	input wire logic [7:0] program_counter_high,
	input wire logic [7:0] program_counter_low,
	input wire logic [7:0] status_flags,
	input wire logic       register_bank_select,
	input wire logic       interrupt_master_enable
);
	timeunit 1ns;
	timeprecision 1ns;
	// One clock domain, reset disables all but the reset check
	default clocking cb @(posedge clk);
	endclocking
	default disable iff reset;

	property p_reset_vals;
		disable iff (1'b0) reset && clk_en |=> accumulator == 8'h00 &&
			stack_top_pointer == 8'h00 && status_flags == 8'h02 && op_ready;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
	property p_flag_mirror;
		register_bank_select == status_flags[4] && interrupt_master_enable == status_flags[0];
	endproperty
	a_flag_mirror: assert property (p_flag_mirror) else $error("flag mirror wrong");
	property p_irq_block;
		clk_en && !status_flags[0] |=> !irq_take;
	endproperty
	a_irq_block: assert property (p_irq_block) else $error("irq taken while off");
	property p_pc_step;
		op_done && $past(clk_en) && !$past(pc_load_en) |-> {program_counter_high,
			program_counter_low} == {$past(program_counter_high),
			$past(program_counter_low)} + 16'h0002;
	endproperty
	a_pc_step: assert property (p_pc_step) else $error("pc did not step by 2");
	property p_flag_read;
		clk_en && reg_rd_en && reg_rd_addr == 8'hF7 |=> reg_rd_data == $past(status_flags);
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("flag read wrong");
	property p_hidden;
		clk_en && !(reg_rd_en && reg_rd_addr == 8'hF7) |=> reg_rd_data == 8'h00;
	endproperty
	a_hidden: assert property (p_hidden) else $error("core reg visible");
	property p_super_set;
		clk_en && super_enter |=> status_flags[3];
	endproperty
	a_super_set: assert property (p_super_set) else $error("super not set");
	property p_addr_hold;
		clk_en && mem_req && !mem_ack |=> mem_req && mem_addr == $past(mem_addr);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("source addr moved");
	property p_imm_done;
		clk_en && op_ready && op_valid && op_mode == MODE_IMMEDIATE ##1 clk_en |=> op_done;
	endproperty
	a_imm_done: assert property (p_imm_done) else $error("immediate late");
	property p_mem_done;
		clk_en && mem_req && mem_ack ##1 clk_en |-> !mem_req ##1 op_done;
	endproperty
	a_mem_done: assert property (p_mem_done) else $error("direct op late");
	// Main scenarios seen
	c_refused: cover property (op_refused);
	c_irq: cover property (irq_take);
	c_ack: cover property (mem_req && mem_ack);
endmodule

bind cpu_core_register_set cpu_core_register_set_sva #(.PC_W(PC_W)) u_sva (
	.clk(clk), .reset(reset), .clk_en(clk_en), .op_valid(op_valid), .op_mode(op_mode),
	.op_ready(op_ready), .op_done(op_done), .op_refused(op_refused), .mem_req(mem_req),
	.mem_addr(mem_addr), .mem_ack(mem_ack), .pc_load_en(pc_load_en),
	.super_enter(super_enter), .irq_take(irq_take), .reg_rd_en(reg_rd_en),
	.reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .accumulator(accumulator),
	.stack_top_pointer(stack_top_pointer), .program_counter_high(program_counter_high),
	.program_counter_low(program_counter_low), .status_flags(status_flags),
	.register_bank_select(register_bank_select),
	.interrupt_master_enable(interrupt_master_enable)
);

//--- tb/cpu_core_register_set_tb.sv
// Self-checking bench for the CPU core register set
module cpu_core_register_set_tb
	import cpu_core_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, reset, clk_en, op_valid, mem_ack, pc_load_en;
	logic        super_enter, super_leave, irq_pending, reg_rd_en;
	logic        op_ready, op_done, op_refused, mem_req, irq_take;
	logic        register_bank_select, interrupt_master_enable;
	alu_op_t     op_kind;
	addr_mode_t  op_mode;
	dest_t       op_dest;
	stack_cmd_t  stack_cmd;
	logic [7:0]  op_operand, mem_rdata, reg_rd_addr, mem_addr, reg_rd_data;
	logic [7:0]  accumulator, index_offset, stack_top_pointer, status_flags;
	logic [7:0]  program_counter_high, program_counter_low;
	logic [15:0] pc_load_val, pc_exp;
	int          n_errors, tests_run;
	// Stack moves and resulting pointer, starting from zero
	stack_cmd_t  cmds[5] = '{STK_PUSH, STK_CALL, STK_POP, STK_RET, STK_RETURN_FROM_INTERRUPT_OP};
	logic [7:0]  sps[5] = '{8'h01, 8'h03, 8'h02, 8'h00, 8'hFD};
	// Arithmetic chain from A=80, flags clear: {A, flags}
	alu_op_t     kinds[8] = '{OP_SUB, OP_ADC, OP_XOR, OP_SHL, OP_SHL, OP_SBB, OP_OR, OP_SHR};
	logic [7:0]  opnds[8] = '{8'h81, 8'h00, 8'h5A, 8'h00, 8'h00, 8'h67, 8'h81, 8'h00};
	logic [15:0] exps[8] = '{16'hFF04, 16'h0006, 16'h5A00, 16'hB400, 16'h6804, 16'h0002,
		16'h8100, 16'h4004};

	cpu_core_register_set #(.PC_W(16)) uut (
		.clk                     (clk),
		.reset                   (reset),
		.clk_en                  (clk_en),
		.op_valid                (op_valid),
		.op_kind                 (op_kind),
		.op_mode                 (op_mode),
		.op_dest                 (op_dest),
		.op_operand              (op_operand),
		.op_ready                (op_ready),
		.op_done                 (op_done),
		.op_refused              (op_refused),
		.mem_req                 (mem_req),
		.mem_addr                (mem_addr),
		.mem_ack                 (mem_ack),
		.mem_rdata               (mem_rdata),
		.stack_cmd               (stack_cmd),
		.pc_load_en              (pc_load_en),
		.pc_load_val             (pc_load_val),
		.super_enter             (super_enter),
		.super_leave             (super_leave),
		.irq_pending             (irq_pending),
		.irq_take                (irq_take),
		.reg_rd_en               (reg_rd_en),
		.reg_rd_addr             (reg_rd_addr),
		.reg_rd_data             (reg_rd_data),
		.accumulator             (accumulator),
		.index_offset            (index_offset),
		.stack_top_pointer       (stack_top_pointer),
		.program_counter_high    (program_counter_high),
		.program_counter_low     (program_counter_low),
		.status_flags            (status_flags),
		.register_bank_select    (register_bank_select),
		.interrupt_master_enable (interrupt_master_enable)
	);

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Compare and count
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// One operation: offer, serve the source read, wait for retire
	task automatic run(input alu_op_t k, input addr_mode_t m, input dest_t d,
			input logic [7:0] opnd, input logic [7:0] rd, input logic [7:0] ea);
		op_kind = k;
		op_mode = m;
		op_dest = d;
		op_operand = opnd;
		op_valid = 1'b1;
		@(negedge clk);
		op_valid = 1'b0;
		// Memory phase only for direct and indexed sources
		if (m != MODE_IMMEDIATE) begin
			for (int i = 0; i < 20 && mem_req !== 1'b1; i++) @(negedge clk);
			check(mem_addr, ea);
			mem_ack = 1'b1;
			mem_rdata = rd;
			@(negedge clk);
			mem_ack = 1'b0;
			mem_rdata = ~rd;
		end
		for (int i = 0; i < 20 && op_done !== 1'b1; i++) @(negedge clk);
		pc_exp = pc_exp + 16'h0002;
		check({op_done, op_ready}, 2'h3);
		check({program_counter_high, program_counter_low}, pc_exp);
	endtask

	// Register space read, answer one cycle later
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_rd_en = 1'b1;
		reg_rd_addr = a;
		@(negedge clk);
		reg_rd_en = 1'b0;
		check(reg_rd_data, exp);
	endtask

	// Verdict and end of run
	task automatic results();
		$display("Checks %0d, errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		#50000;
		n_errors++;
		results();
	end

	// Main sequence
	initial begin
		{reset, clk_en, op_valid, mem_ack, pc_load_en} = 5'h18;
		{super_enter, super_leave, irq_pending, reg_rd_en} = 4'h0;
		op_kind = OP_MOV;
		op_mode = MODE_IMMEDIATE;
		op_dest = DST_ACC;
		stack_cmd = STK_NONE;
		{op_operand, mem_rdata, reg_rd_addr} = 24'h000000;
		pc_load_val = 16'h0000;
		pc_exp = 16'h0000;
		n_errors = 0;
		tests_run = 0;
		repeat (12) @(negedge clk);
		reset = 1'b0;
		check({accumulator, index_offset, stack_top_pointer, program_counter_high,
			program_counter_low, status_flags}, 48'h000000000002);
		rd(8'hF7, 8'h02);
		rd(8'h00, 8'h00);
		$display("Test reset done");
		run(OP_ADD, MODE_IMMEDIATE, DST_ACC, 8'h07, 8'h00, 8'h00);
		check({accumulator, status_flags}, 16'h0700);
		check(op_refused, 1'b0);
		run(OP_MOV, MODE_IMMEDIATE, DST_INDEX, 8'h10, 8'h00, 8'h00);
		check({index_offset, status_flags}, 16'h1000);
		run(OP_ADD, MODE_DIRECT, DST_ACC, 8'h20, 8'hF9, 8'h20);
		check({accumulator, status_flags}, 16'h0006);
		run(OP_ADD, MODE_INDEXED, DST_ACC, 8'hF5, 8'h01, 8'h05);
		check({accumulator, status_flags}, 16'h0100);
		run(OP_ADD, MODE_IMMEDIATE, DST_INDEX, 8'h01, 8'h00, 8'h00);
		check({index_offset, status_flags}, 16'h1100);
		$display("Test operations done");
		run(OP_OR, MODE_IMMEDIATE, DST_FLAGS, 8'h19, 8'h00, 8'h00);
		check({register_bank_select, interrupt_master_enable, status_flags}, 10'h311);
		rd(8'hF7, 8'h11);
		irq_pending = 1'b1;
		@(negedge clk);
		check(irq_take, 1'b1);
		run(OP_XOR, MODE_IMMEDIATE, DST_FLAGS, 8'hFF, 8'h00, 8'h00);
		check({op_refused, status_flags}, 9'h111);
		run(OP_AND, MODE_IMMEDIATE, DST_FLAGS, 8'hEE, 8'h00, 8'h00);
		check(status_flags, 8'h00);
		@(negedge clk);
		check(irq_take, 1'b0);
		irq_pending = 1'b0;
		super_enter = 1'b1;
		@(negedge clk);
		super_enter = 1'b0;
		run(OP_AND, MODE_IMMEDIATE, DST_FLAGS, 8'h00, 8'h00, 8'h00);
		check(status_flags, 8'h08);
		super_leave = 1'b1;
		@(negedge clk);
		super_leave = 1'b0;
		check(status_flags, 8'h00);
		$display("Test flags done");
		foreach (cmds[i]) begin
			stack_cmd = cmds[i];
			@(negedge clk);
			stack_cmd = STK_NONE;
			check(stack_top_pointer, sps[i]);
		end
		run(OP_ADD, MODE_IMMEDIATE, DST_SP, 8'h03, 8'h00, 8'h00);
		check({stack_top_pointer, status_flags}, 16'h0000);
		run(OP_SWAP, MODE_IMMEDIATE, DST_SP, 8'h00, 8'h00, 8'h00);
		check({stack_top_pointer, accumulator}, 16'h0100);
		run(OP_MOV, MODE_DIRECT, DST_FLAGS, 8'h30, 8'hFF, 8'h30);
		check({op_refused, status_flags, stack_top_pointer}, 17'h10001);
		$display("Test stack done");
		pc_load_en = 1'b1;
		pc_load_val = 16'h1FFE;
		@(negedge clk);
		pc_load_en = 1'b0;
		pc_exp = 16'h1FFE;
		run(OP_MOV, MODE_IMMEDIATE, DST_ACC, 8'h80, 8'h00, 8'h00);
		check(accumulator, 8'h80);
		foreach (kinds[i]) begin
			run(kinds[i], MODE_IMMEDIATE, DST_ACC, opnds[i], 8'h00, 8'h00);
			check({accumulator, status_flags}, exps[i]);
		end
		// Frozen clock enable holds the stack pointer
		clk_en = 1'b0;
		stack_cmd = STK_PUSH;
		repeat (3) @(negedge clk);
		check(stack_top_pointer, 8'h01);
		stack_cmd = STK_NONE;
		clk_en = 1'b1;
		$display("Test counter and freeze done");
		// Reset in mid-run returns every register to its start value
		reset = 1'b1;
		@(negedge clk);
		reset = 1'b0;
		check({accumulator, index_offset, stack_top_pointer, program_counter_high,
			program_counter_low, status_flags}, 48'h000000000002);
		check(op_ready, 1'b1);
		$display("Test mid-run reset done");
		results();
	end
endmodule
